// file: core/ssrp_defs.vh
// constants for the synchronous memory read port and clocking block
// assumes inclusion by core/ssrp_core.v only
`ifndef SSRP_DEFS_VH
`define SSRP_DEFS_VH

// default data word width
`define SSRP_DATA_W        18
// default address width, a plain choice
`define SSRP_ADDR_W        8
// words per read burst
`define SSRP_BURST_LEN     2
// fastest clock rate with the delay loop off, in MHz
`define SSRP_SCM_MAX_MHZ   167

// read sequencer states
`define SSRP_ST_IDLE       2'h0
`define SSRP_ST_WORD0      2'h1
`define SSRP_ST_WORD1      2'h2

// bit positions of the pins in the synchroniser word
`define SSRP_SYN_K         0
`define SSRP_SYN_KN        1
`define SSRP_SYN_C         2
`define SSRP_SYN_CN        3
`define SSRP_SYN_RSEL      4
`define SSRP_SYN_WSEL      5
`define SSRP_SYN_SCM       6
`define SSRP_SYN_DLL_DIS   7
`define SSRP_SYN_ADDR_LSB  8

`endif

// file: core/ssrp_core.v
// read port and clocking of a pipelined static memory with split data ports
// assumes all strobes and pin inputs come from outside the clock domain and
// are far slower than clock; every such input passes two flops first
//
// Overview of operation
// - read data changes on both output strobe rises, input strobes in single mode
// - read data pins float whenever no read is being delivered
// - read select sampled low at positive input strobe rise starts a read
// - deselect lets current burst finish, drivers float after next positive output strobe rise, input strobe in single mode
// - each read delivers exactly two words in sequence
// - every access starts at a rising edge of the positive input strobe
// - synchronous inputs registered at positive input strobe rise
// - inputs for that edge also registered at negative input strobe rise
// - read data launched from the output strobe pair, skewable by controller
// - echo strobes toggle continuously, following the output strobe pair
// - in single mode echo strobes follow the input strobe pair
// - read address taken at positive, write address at negative strobe rise
// - write select low at positive strobe rise starts write, else write ignored
// - delay loop disable low selects single-rate latency mode, up to 167 MHz
`timescale 1ns/1ps
`include "ssrp_defs.vh"

module ssrp_core
#(
  parameter DATA_W     = `SSRP_DATA_W,
  parameter ADDR_W     = `SSRP_ADDR_W,
  parameter SCM_MAX_MHZ = `SSRP_SCM_MAX_MHZ
)
(
  input  wire                clock,
  input  wire                reset_n,
  input  wire                in_strobe_p,
  input  wire                in_strobe_n,
  input  wire                out_strobe_p,
  input  wire                out_strobe_n,
  input  wire                single_clock_mode,
  input  wire                dll_disable_n,
  input  wire                read_port_select_n,
  input  wire                write_port_select_n,
  input  wire [ADDR_W-1:0]   addr,
  input  wire [DATA_W-1:0]   mem_word0,
  input  wire [DATA_W-1:0]   mem_word1,
  output reg  [DATA_W-1:0]   read_data_out,
  output reg                 read_data_oe,
  output reg                 echo_strobe_p,
  output reg                 echo_strobe_n,
  output reg                 mem_read_req,
  output reg  [ADDR_W-1:0]   mem_read_addr,
  output reg                 write_start,
  output reg  [ADDR_W-1:0]   write_addr,
  output reg                 latency_single_mode
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  localparam SYN_W = `SSRP_SYN_ADDR_LSB + ADDR_W;

  wire [SYN_W-1:0] raw_in;
  reg  [SYN_W-1:0] sync1_reg;
  reg  [SYN_W-1:0] sync2_reg;

  assign raw_in = {addr, dll_disable_n, single_clock_mode, write_port_select_n,
                   read_port_select_n, out_strobe_n, out_strobe_p, in_strobe_n,
                   in_strobe_p};

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_reg <= {SYN_W{1'b0}};
      sync2_reg <= {SYN_W{1'b0}};
    end
    else
    begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire              k_s         = sync2_reg[`SSRP_SYN_K];
  wire              kn_s        = sync2_reg[`SSRP_SYN_KN];
  wire              c_s         = sync2_reg[`SSRP_SYN_C];
  wire              cn_s        = sync2_reg[`SSRP_SYN_CN];
  wire              rsel_n_s    = sync2_reg[`SSRP_SYN_RSEL];
  wire              wsel_n_s    = sync2_reg[`SSRP_SYN_WSEL];
  wire              scm_s       = sync2_reg[`SSRP_SYN_SCM];
  wire              dll_dis_n_s = sync2_reg[`SSRP_SYN_DLL_DIS];
  wire [ADDR_W-1:0] addr_s      = sync2_reg[SYN_W-1:`SSRP_SYN_ADDR_LSB];

  wire k_rise;
  wire kn_rise;
  wire c_rise;
  wire cn_rise;

  // one finder per strobe, each fed only from the second stage
  ssrp_rise_det i_rise_k
  (
    .clock   (clock),
    .reset_n (reset_n),
    .level   (k_s),
    .rise    (k_rise)
  );

  ssrp_rise_det i_rise_kn
  (
    .clock   (clock),
    .reset_n (reset_n),
    .level   (kn_s),
    .rise    (kn_rise)
  );

  ssrp_rise_det i_rise_c
  (
    .clock   (clock),
    .reset_n (reset_n),
    .level   (c_s),
    .rise    (c_rise)
  );

  ssrp_rise_det i_rise_cn
  (
    .clock   (clock),
    .reset_n (reset_n),
    .level   (cn_s),
    .rise    (cn_rise)
  );

  // ************************************************************
  // launch strobe selection
  // ************************************************************
  // single mode swaps the output pair for the input pair
  wire launch_p    = scm_s ? k_rise : c_rise;
  wire launch_n    = scm_s ? kn_rise : cn_rise;
  wire launch_p_lv = scm_s ? k_s : c_s;
  wire launch_n_lv = scm_s ? kn_s : cn_s;

  // ************************************************************
  // read select and latency mode capture
  // ************************************************************
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mem_read_req        <= 1'b0;
      mem_read_addr       <= {ADDR_W{1'b0}};
      latency_single_mode <= 1'b0;
    end
    else
    begin
      // delay loop off selects the single-rate latency timing
      latency_single_mode <= ~dll_dis_n_s;
      mem_read_req        <= k_rise & ~rsel_n_s;
      if (k_rise && !rsel_n_s)
        mem_read_addr <= addr_s;
    end
  end

  // ************************************************************
  // write select and write address capture
  // ************************************************************
  // select is judged at the positive strobe only; the controller may
  // drop it before the negative strobe brings the address
  reg write_armed_reg;

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      write_armed_reg <= 1'b0;
      write_start     <= 1'b0;
      write_addr      <= {ADDR_W{1'b0}};
    end
    else
    begin
      write_start <= 1'b0;
      if (k_rise)
        write_armed_reg <= ~wsel_n_s;
      else if (kn_rise)
        write_armed_reg <= 1'b0;
      if (kn_rise && write_armed_reg)
      begin
        write_start <= 1'b1;
        write_addr  <= addr_s;
      end
    end
  end

  // ************************************************************
  // read burst sequencer
  // ************************************************************
  localparam [1:0] ST_IDLE  = `SSRP_ST_IDLE;
  localparam [1:0] ST_WORD0 = `SSRP_ST_WORD0;
  localparam [1:0] ST_WORD1 = `SSRP_ST_WORD1;

  reg [1:0]        state_reg;
  reg [1:0]        state_next;
  reg              read_pend_reg;
  reg              read_pend_next;
  reg [DATA_W-1:0] hold0_reg;
  reg [DATA_W-1:0] hold1_reg;
  reg [DATA_W-1:0] word1_reg;

  always @*
  begin
    read_pend_next = read_pend_reg;
    state_next     = state_reg;
    if (mem_read_req)
      read_pend_next = 1'b1;
    case (state_reg)
      ST_IDLE:
        if (launch_p && read_pend_reg)
          state_next = ST_WORD0;
      ST_WORD0:
        if (launch_n)
          state_next = ST_WORD1;
      ST_WORD1:
        if (launch_p)
          state_next = read_pend_reg ? ST_WORD0 : ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
    if (launch_p && read_pend_reg && state_reg != ST_WORD0 && !mem_read_req)
      read_pend_next = 1'b0;
  end

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg     <= ST_IDLE;
      read_pend_reg <= 1'b0;
      hold0_reg     <= {DATA_W{1'b0}};
      hold1_reg     <= {DATA_W{1'b0}};
      word1_reg     <= {DATA_W{1'b0}};
      read_data_out <= {DATA_W{1'b0}};
      read_data_oe  <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      read_pend_reg <= read_pend_next;
      // fetched words wait here until the burst that owns them starts
      if (mem_read_req)
      begin
        hold0_reg <= mem_word0;
        hold1_reg <= mem_word1;
      end
      // second word parked at burst start: in single mode the next
      // fetch lands before this burst's negative launch edge
      if (state_next == ST_WORD0 && state_reg != ST_WORD0)
      begin
        read_data_out <= hold0_reg;
        word1_reg     <= hold1_reg;
      end
      else if (state_next == ST_WORD1 && state_reg == ST_WORD0)
        read_data_out <= word1_reg;
      // drivers float only after the positive launch edge ends the burst
      read_data_oe <= (state_next != ST_IDLE);
    end
  end

  // ************************************************************
  // echo strobes
  // ************************************************************
  // free-running copies of the launch pair, so they move with any skew
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      echo_strobe_p <= 1'b0;
      echo_strobe_n <= 1'b0;
    end
    else
    begin
      echo_strobe_p <= launch_p_lv;
      echo_strobe_n <= launch_n_lv;
    end
  end

endmodule

// ************************************************************
// rising edge finder for one synchronised strobe
// ************************************************************
// prev flop resets to the idle pin level, so release gives no false edge
module ssrp_rise_det
#(
  parameter RESET_LEVEL = 1'b0
)
(
  input  wire clock,
  input  wire reset_n,
  input  wire level,
  output wire rise
);

  reg prev_reg;

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      prev_reg <= RESET_LEVEL;
    else
      prev_reg <= level;
  end

  assign rise = level & ~prev_reg;

endmodule

// file: verif/ssrp_properties.sv
// port timing assertions for the read port and echo strobes
// assumes pins quiet in reset, strobes eight clocks per period
`timescale 1ns/1ps
module ssrp_checker
#(parameter ADDR_W = 8)
(
  input wire              clock,
  input wire              reset_n,
  input wire              in_strobe_p,
  input wire              in_strobe_n,
  input wire              out_strobe_p,
  input wire              out_strobe_n,
  input wire              single_clock_mode,
  input wire              dll_disable_n,
  input wire              read_port_select_n,
  input wire              write_port_select_n,
  input wire [ADDR_W-1:0] addr,
  input wire              read_data_oe,
  input wire              echo_strobe_p,
  input wire              echo_strobe_n,
  input wire              mem_read_req,
  input wire              write_start,
  input wire [ADDR_W-1:0] write_addr,
  input wire              latency_single_mode
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // mode guard: the launch mux is itself synchronised
  property p_echo_p;
    $past(single_clock_mode, 4) == single_clock_mode |->
      echo_strobe_p == (single_clock_mode ? $past(in_strobe_p, 3) : $past(out_strobe_p, 3));
  endproperty
  property p_echo_n;
    $past(single_clock_mode, 4) == single_clock_mode |->
      echo_strobe_n == (single_clock_mode ? $past(in_strobe_n, 3) : $past(out_strobe_n, 3));
  endproperty
  property p_req_sel; mem_read_req |-> !$past(read_port_select_n, 3); endproperty
  property p_req_pulse; mem_read_req |=> !mem_read_req [*6]; endproperty
  property p_oe_follows; mem_read_req |-> ##[1:16] read_data_oe; endproperty
  property p_oe_hold; $rose(read_data_oe) |-> read_data_oe [*7]; endproperty
  property p_write;
    write_start |-> !$past(write_port_select_n, 7) && write_addr == $past(addr, 3);
  endproperty
  property p_latency; $stable(dll_disable_n) [*5] |-> latency_single_mode == !dll_disable_n; endproperty
  a_echo_p:
    assert property (p_echo_p) else $error("echo p wrong");
  a_echo_n:
    assert property (p_echo_n) else $error("echo n wrong");
  a_req_sel:
    assert property (p_req_sel) else $error("read without select");
  a_req_pulse:
    assert property (p_req_pulse) else $error("read starts too close");
  a_oe_follows:
    assert property (p_oe_follows) else $error("no read data");
  a_oe_hold:
    assert property (p_oe_hold) else $error("burst cut short");
  a_write:
    assert property (p_write) else $error("write start wrong");
  a_latency:
    assert property (p_latency) else $error("latency mode wrong");
  c_read: cover property (mem_read_req);
  c_write: cover property (write_start);
  c_single: cover property (read_data_oe && single_clock_mode);
endmodule
bind ssrp_core ssrp_checker #(.ADDR_W(ADDR_W)) i_ssrp_checker (.*);

// file: verif/ssrp_ctrl_model.sv
// controller-side strobe source: input pair and a skewed output pair
// assumes run rises once after reset and stays high
`timescale 1ns/1ps
module ssrp_ctrl_model
#(parameter SKEW = 45)
(
  input wire run,
  output reg in_strobe_p,
  output reg in_strobe_n,
  output reg out_strobe_p,
  output reg out_strobe_n
);
  initial {in_strobe_p, in_strobe_n, out_strobe_p, out_strobe_n} = 4'h0;
  always @(in_strobe_p) out_strobe_p <= #SKEW in_strobe_p;
  always @(in_strobe_n) out_strobe_n <= #SKEW in_strobe_n;
  // strobes stand still until run, then 160 ns per period
  initial
  begin
    wait (run);
    #7;
    forever
    begin
      in_strobe_p = 1'b1;
      #80 in_strobe_p = 1'b0;
      in_strobe_n = 1'b1;
      #80 in_strobe_n = 1'b0;
    end
  end
endmodule

// file: verif/tb_top.sv
// self-checking bench: selects and address per strobe period, read capture
// assumes the strobe model runs free after reset
`timescale 1ns/1ps
module tb_top;
  reg         clock = 0, reset_n = 0, single_clock_mode = 0, dll_disable_n = 1, run = 0;
  reg         read_port_select_n = 1, write_port_select_n = 1, oe_q = 0;
  reg  [7:0]  addr = 8'h00;
  wire        in_strobe_p, in_strobe_n, out_strobe_p, out_strobe_n, read_data_oe;
  wire        mem_read_req, write_start, latency_single_mode, echo_strobe_p, echo_strobe_n;
  wire [17:0] mem_word0, mem_word1, read_data_out;
  wire [7:0]  mem_read_addr, write_addr;
  reg  [17:0] data_q, words[$];
  reg  [7:0]  waddrs[$];
  int         errors = 0, compares = 0, reqs = 0, drops = 0;
  function automatic logic [17:0] word(input logic [7:0] a, input logic second);
    word = second ? {10'h15A, ~a} : {10'h2A5, a};
  endfunction
  assign mem_word0 = word(mem_read_addr, 1'b0);
  assign mem_word1 = word(mem_read_addr, 1'b1);
  always #10 clock = ~clock;
  ssrp_ctrl_model i_ssrp_ctrl_model (.*);
  ssrp_core i_ssrp_core (.*);
  // ****************
  // capture and tasks
  // ****************
  always @(posedge clock)
  begin
    if (read_data_oe && (!oe_q || read_data_out !== data_q)) words.push_back(read_data_out);
    if (oe_q && !read_data_oe) drops++;
    if (write_start) waddrs.push_back(write_addr);
    if (mem_read_req) reqs++;
    oe_q <= read_data_oe;
    data_q <= read_data_out;
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // selects and read address ahead of in_strobe_p, write address ahead of in_strobe_n
  task period(input logic rs, input logic ws, input logic [7:0] ra, input logic [7:0] wa);
    @(posedge in_strobe_n);
    repeat (2) @(posedge clock);
    #1 {read_port_select_n, write_port_select_n, addr} = {rs, ws, ra};
    @(posedge in_strobe_p);
    repeat (2) @(posedge clock);
    #1 addr = wa;
  endtask
  task sc_read(input logic [7:0] a, input logic [7:0] b, input logic two);
    words.delete();
    reqs = 0;
    drops = 0;
    period(0, 1, a, 8'h00);
    period(!two, 1, b, 8'h00);
    repeat (3) period(1, 1, 8'h00, 8'h00);
    check("reads", reqs, two ? 2 : 1);
    check("words", words.size(), two ? 4 : 2);
    check("word0", words[0], word(a, 0));
    check("word1", words[1], word(a, 1));
    if (two) check("word2", words[2], word(b, 0));
    if (two) check("word3", words[3], word(b, 1));
    check("oe drops", drops, 1);
    check("oe idle", read_data_oe, 0);
  endtask
  task sc_write_only;
    waddrs.delete();
    reqs = 0;
    period(1, 0, 8'h11, 8'h5A);
    period(1, 1, 8'h22, 8'h77);
    period(1, 1, 8'h00, 8'h00);
    check("writes", waddrs.size(), 1);
    check("write addr", waddrs[0], 8'h5A);
    check("deselected reads", reqs, 0);
    check("oe deselected", read_data_oe, 0);
  endtask
  task sc_single;
    single_clock_mode = 1;
    dll_disable_n = 0;
    repeat (2) period(1, 1, 8'h00, 8'h00);
    check("latency mode", latency_single_mode, 1);
    sc_read(8'h0F, 8'hF0, 1);
  endtask
  task tally_and_finish;
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    #1 reset_n = 1;
    run = 1;
    sc_read(8'h3C, 8'h00, 0);
    sc_read(8'hA5, 8'h5B, 1);
    sc_write_only;
    sc_single;
    tally_and_finish;
  end
  initial
  begin
    #100000;
    errors++;
    tally_and_finish;
  end
endmodule
